/* File: csc_params.svh */
// shared command codes, field positions, reset values and encodings
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

// link command codes
`define CMD_PAGE 8'h00
`define CMD_CLEAR 8'h03
`define CMD_PHASE 8'h04
`define CMD_STORE 8'h11
`define CMD_GAIN 8'h38
`define CMD_CML 8'h7e
`define CMD_IOUT 8'h8c
`define CMD_IMAX 8'hda
`define CMD_ISC 8'hdc

// transaction kinds on the link
`define KIND_SEND 2'h0
`define KIND_BYTE 2'h1
`define KIND_WORD 2'h2
`define KIND_BLOCK 2'h3

// page and phase selectors
`define PAGE_ALL 8'hff
`define PHASE_ALL 8'hff
`define PHASE_TOTAL 8'h80

// gain calibration word
`define GAIN_EXP 5'h1a
`define GAIN_MAN_MIN 11'h131
`define GAIN_MAN_MAX 11'h150
`define GAIN_MAN_DEF 11'h140
`define GAIN_NOM2 10'h280
`define RECIP_320 8'hcd

// output current readback word, exponent -4
`define IOUT_EXP 5'h1c
`define IOUT_MAN_MAX 11'h3ff

// input sense and input max configuration
`define ISC_DEF 16'hc000
`define IMAX0_DEF 16'h3200
`define IMAX1_DEF 16'h0000
`define ISC_SEL_HI 15
`define ISC_SEL_LO 14
`define ISC_ZERO_BIT 13
`define ISC_TRIM_HI 12
`define BOOST_BIT 13

// communication fault flags
`define CML_BAD_CMD 7
`define CML_BAD_DATA 6

// maximum temperature decode
`define TEMP_BASE 8'h5a
`define TEMP_STEP 8'h05

// effective input gain in micro-ohm
`define AIN_0 13'h0096
`define AIN_1 13'h00fa
`define AIN_2 13'h012c
`define AIN_3 13'h01f4
`define AIN_4 13'h04b0
`define AIN_5 13'h07d0
`define AIN_6 13'h0960
`define AIN_7 13'h0fa0

// host controller register map
`define HREG_CMD 8'h00
`define HREG_WDATA 8'h04
`define HREG_RDATA 8'h08
`define HREG_STATUS 8'h0c
`define HST_BUSY 0
`define HST_DONE 1
`define HST_NAK 2
`define HST_REFUSED 3
`define HST_ALERT 4

`endif

/* File: csc_pkg.sv */
// types used by the host end of the calibration link
package csc_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic {HS_IDLE, HS_WAIT} host_state_t;
endpackage

/* File: pmbus_word_if.sv */
// word-level command link between host controller and calibration regs
`timescale 1ns/10ps
`default_nettype none
interface pmbus_word_if;
    logic req;
    logic [7:0] cmd;
    logic [1:0] kind;
    logic wr;
    logic [15:0] wdata;
    logic ack;
    logic nak;
    logic [15:0] rdata;
    logic host_alert_line;
    modport device (
        input req,
        input cmd,
        input kind,
        input wr,
        input wdata,
        output ack,
        output nak,
        output rdata,
        output host_alert_line
    );
    modport host (
        output req,
        output cmd,
        output kind,
        output wr,
        output wdata,
        input ack,
        input nak,
        input rdata,
        input host_alert_line
    );
endinterface
`default_nettype wire

/* File: gain_scaler.sv */
// applies a gain calibration mantissa to one raw current reading
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"
module gain_scaler #(
    parameter int W = 16
) (
    input wire logic [W-1:0] raw,
    input wire logic [10:0] mant,
    output logic [W-1:0] scaled
);
    logic [9:0] factor;
    logic [W+17:0] prod;
    logic [W+1:0] quot;

    // raw is nominal 5 mV/A; 320/mant taken as 2 - mant/320 near nominal
    assign factor = `GAIN_NOM2 - mant[9:0];
    assign prod = (W+18)'(raw) * (W+18)'(factor) * (W+18)'(`RECIP_320);
    assign quot = prod[W+17:16];
    // saturate rather than wrap on large readings
    assign scaled = (|quot[W+1:W]) ? {W{1'b1}} : quot[W-1:0];
endmodule // gain_scaler
`default_nettype wire

/* File: current_sense_calibration_regs.sv */
// device end: paged current sense configuration and gain calibration
// What this block does
// - input sense config takes word accesses only
// - host selects page zero for input config
// - bits 15:14 shunt gain selector, nvm loaded
// - host leaves factory trim bits untouched
// - boost and selector decode effective input gain
// - temperature code 0..7 gives 90..125 C
// - current readback follows selected page and phase
// - page then phase then readback gives phase
// - phase 80h reads channel total current
// - phase 80h calibrates the channel total
// - raw phase current nominally 5 mV/A
// - command 38h holds output current gain
// - gain calibration takes word accesses only
// - page 0/1 selects channel, FFh both
// - phase index, FFh all, 80h total
// - gain exponent read only, mantissa writable
// - calibration volatile until store-all command
// - host tunes max scaling after coarse gain
// - boost bit 13 of page-1 max config
// - gain exponent fixed at minus six
// - bad gain write discarded, fault, alert
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"
module current_sense_calibration_regs #(
    parameter int NPH = 6
) (
    input wire logic clk,
    input wire logic rst,
    pmbus_word_if.device bus,
    input wire logic [2*NPH*16-1:0] phase_sample_flat,
    input wire logic [2:0] max_temperature_sel,
    output logic [12:0] input_gain_uohm,
    output logic [7:0] max_temperature_c,
    output logic nvm_store_pulse
);
    localparam int NS = NPH + 1;
    localparam int IW = $clog2(NS);

    logic [7:0] page_r, phase_r, cml_r, temp_r;
    logic [15:0] isc_r, isc_nv_r, rdata_r;
    logic [15:0] imax_r [2];
    logic [15:0] imax_nv_r [2];
    logic [10:0] gain_r [2][NS];
    logic [10:0] gain_nv_r [2][NS];
    logic load_r, ack_r, nak_r, alert_r, store_r;
    logic [12:0] in_gain_r;

    // request decode
    logic take, is_send, is_byte, is_word, ok_kind, bad_cmd, good;
    logic page_ok, phase_ok, phase_in_range, gain_val_ok, gain_wr, gain_bad, gain_do;
    logic isc_wr, imax_wr, store_do, rd_ch, boost;
    logic [7:0] cml_set, cml_clr, cml_nxt;
    logic [1:0] ch_hit;
    logic [2*NS-1:0] gain_hit;
    logic [IW-1:0] rd_idx;
    logic [15:0] scaled [2][NS];
    logic [18:0] sum_w [2];
    logic [15:0] tot_raw [2];
    logic [15:0] iout_sel, gain_word, rd_word;
    logic [10:0] iout_man;

    // a request is taken once; the ack cycle blocks a second take
    assign take = bus.req & ~ack_r & ~load_r;
    assign is_send = bus.kind == `KIND_SEND;
    assign is_byte = bus.kind == `KIND_BYTE;
    assign is_word = bus.kind == `KIND_WORD;
    assign ok_kind =
        (bus.cmd == `CMD_PAGE || bus.cmd == `CMD_PHASE) ? is_byte :
        (bus.cmd == `CMD_CLEAR || bus.cmd == `CMD_STORE) ? (is_send & bus.wr) :
        (bus.cmd == `CMD_CML) ? is_byte :
        (bus.cmd == `CMD_ISC) ? is_word :
        (bus.cmd == `CMD_GAIN) ? is_word :
        (bus.cmd == `CMD_IMAX) ? is_word :
        (bus.cmd == `CMD_IOUT) ? (is_word & ~bus.wr) : 1'b0;
    assign bad_cmd = take & ~ok_kind;
    assign good = take & ok_kind & bus.wr;

    // page and phase routing of calibration writes
    assign page_ok = (page_r == 8'h00) | (page_r == 8'h01) | (page_r == `PAGE_ALL);
    assign phase_in_range = phase_r < 8'(NPH);
    assign phase_ok = phase_in_range | (phase_r == `PHASE_ALL) | (phase_r == `PHASE_TOTAL);
    assign gain_val_ok = (bus.wdata[15:11] == `GAIN_EXP) &
        (bus.wdata[10:0] >= `GAIN_MAN_MIN) & (bus.wdata[10:0] <= `GAIN_MAN_MAX);
    assign gain_wr = good & (bus.cmd == `CMD_GAIN);
    assign gain_bad = gain_wr & ~(gain_val_ok & page_ok & phase_ok);
    assign gain_do = gain_wr & ~gain_bad;
    assign ch_hit[0] = (page_r == 8'h00) | (page_r == `PAGE_ALL);
    assign ch_hit[1] = (page_r == 8'h01) | (page_r == `PAGE_ALL);
    assign isc_wr = good & (bus.cmd == `CMD_ISC) & ch_hit[0];
    assign imax_wr = good & (bus.cmd == `CMD_IMAX);
    assign store_do = good & (bus.cmd == `CMD_STORE);

    // one select line per channel and phase slot, slot NPH is the total
    genvar gc;
    genvar gp;
    generate
        for (gc = 0; gc < 2; gc++) begin : g_ch
            for (gp = 0; gp < NS; gp++) begin : g_ph
                if (gp < NPH) begin : g_one
                    assign gain_hit[gc*NS+gp] = ch_hit[gc] &
                        ((phase_r == 8'(gp)) | (phase_r == `PHASE_ALL));
                    gain_scaler #(.W(16)) u_scale (
                        .raw(phase_sample_flat[(gc*NPH+gp)*16 +: 16]),
                        .mant(gain_r[gc][gp]),
                        .scaled(scaled[gc][gp])
                    );
                end else begin : g_tot
                    assign gain_hit[gc*NS+gp] = ch_hit[gc] & (phase_r == `PHASE_TOTAL);
                    gain_scaler #(.W(16)) u_scale (
                        .raw(tot_raw[gc]),
                        .mant(gain_r[gc][gp]),
                        .scaled(scaled[gc][gp])
                    );
                end
            end
        end
    endgenerate

    // channel total is the sum of calibrated phases, saturated to 16 bits
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            sum_w[c] = 19'h00000;
            for (int p = 0; p < NPH; p++) begin
                sum_w[c] = sum_w[c] + 19'(scaled[c][p]);
            end
            tot_raw[c] = (|sum_w[c][18:16]) ? 16'hffff : sum_w[c][15:0];
        end
    end

    // read routing; page FFh reads the first channel, phase FFh reads gain slot 0 and zero current
    assign rd_ch = (page_r == 8'h01);
    assign rd_idx = (phase_r == `PHASE_TOTAL) ? IW'(NPH) :
        phase_in_range ? phase_r[IW-1:0] : {IW{1'b0}};
    assign iout_sel = (phase_r == `PHASE_TOTAL) ? scaled[rd_ch][NPH] :
        phase_in_range ? scaled[rd_ch][rd_idx] : 16'h0000;
    // readback in 1/16 A steps; clamp keeps the mantissa positive
    assign iout_man = (|iout_sel[15:10]) ? `IOUT_MAN_MAX : {1'b0, iout_sel[9:0]};
    assign gain_word = {`GAIN_EXP, gain_r[rd_ch][rd_idx]};
    assign rd_word =
        (bus.cmd == `CMD_PAGE) ? {8'h00, page_r} :
        (bus.cmd == `CMD_PHASE) ? {8'h00, phase_r} :
        (bus.cmd == `CMD_CML) ? {8'h00, cml_r} :
        (bus.cmd == `CMD_ISC) ? (ch_hit[0] ? isc_r : 16'h0000) :
        (bus.cmd == `CMD_IMAX) ? imax_r[rd_ch] :
        (bus.cmd == `CMD_GAIN) ? gain_word :
        (bus.cmd == `CMD_IOUT) ? {`IOUT_EXP, iout_man} : 16'h0000;

    // fault flags: a new fault wins over clear in the same cycle
    assign cml_set = {bad_cmd, gain_bad, 6'h00};
    assign cml_clr = (good & (bus.cmd == `CMD_CLEAR)) ? 8'hff :
        (good & (bus.cmd == `CMD_CML)) ? bus.wdata[7:0] : 8'h00;
    assign cml_nxt = (cml_r & ~cml_clr) | cml_set;
    assign boost = imax_r[1][`BOOST_BIT];

    // effective input analog gain decode
    function automatic logic [12:0] ain_lut(input logic [2:0] code);
        case (code)
            3'h0: ain_lut = `AIN_0;
            3'h1: ain_lut = `AIN_1;
            3'h2: ain_lut = `AIN_2;
            3'h3: ain_lut = `AIN_3;
            3'h4: ain_lut = `AIN_4;
            3'h5: ain_lut = `AIN_5;
            3'h6: ain_lut = `AIN_6;
            default: ain_lut = `AIN_7;
        endcase
    endfunction

    // page and phase hold until rewritten
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            page_r <= 8'h00;
            phase_r <= 8'h00;
        end else begin
            if (good & (bus.cmd == `CMD_PAGE)) page_r <= bus.wdata[7:0];
            if (good & (bus.cmd == `CMD_PHASE)) phase_r <= bus.wdata[7:0];
        end
    end

    // input sense and max config; live copy reloads from nvm after reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            isc_r <= `ISC_DEF;
            imax_r[0] <= `IMAX0_DEF;
            imax_r[1] <= `IMAX1_DEF;
        end else if (load_r) begin
            isc_r <= isc_nv_r;
            imax_r <= imax_nv_r;
        end else begin
            // trim bits are stored as written; bit 13 never holds a one
            if (isc_wr) isc_r <= {bus.wdata[15:14], 1'b0, bus.wdata[12:0]};
            if (imax_wr & ch_hit[0]) imax_r[0] <= bus.wdata;
            if (imax_wr & ch_hit[1]) imax_r[1] <= bus.wdata;
        end
    end

    // gain calibration slots, written through the page and phase select
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < 2; c++) begin
                for (int p = 0; p < NS; p++) gain_r[c][p] <= `GAIN_MAN_DEF;
            end
        end else if (load_r) begin
            gain_r <= gain_nv_r;
        end else begin
            for (int c = 0; c < 2; c++) begin
                for (int p = 0; p < NS; p++) begin
                    if (gain_do & gain_hit[c*NS+p]) gain_r[c][p] <= bus.wdata[10:0];
                end
            end
        end
    end

    // nonvolatile image, only updated by the store-all command
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            isc_nv_r <= `ISC_DEF;
            imax_nv_r[0] <= `IMAX0_DEF;
            imax_nv_r[1] <= `IMAX1_DEF;
            for (int c = 0; c < 2; c++) begin
                for (int p = 0; p < NS; p++) gain_nv_r[c][p] <= `GAIN_MAN_DEF;
            end
            load_r <= 1'b1;
            store_r <= 1'b0;
        end else begin
            load_r <= 1'b0;
            store_r <= store_do;
            if (store_do) begin
                isc_nv_r <= isc_r;
                imax_nv_r <= imax_r;
                gain_nv_r <= gain_r;
            end
        end
    end

    // answer, fault flags, alert and user-side decodes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
            nak_r <= 1'b0;
            rdata_r <= 16'h0000;
            cml_r <= 8'h00;
            alert_r <= 1'b0;
            in_gain_r <= `AIN_0;
            temp_r <= `TEMP_BASE;
        end else begin
            ack_r <= take;
            nak_r <= bad_cmd | gain_bad;
            if (take & ~bus.wr) rdata_r <= rd_word;
            cml_r <= cml_nxt;
            alert_r <= |cml_nxt;
            in_gain_r <= ain_lut({boost, isc_r[`ISC_SEL_HI:`ISC_SEL_LO]});
            temp_r <= `TEMP_BASE + 8'(max_temperature_sel) * `TEMP_STEP;
        end
    end

    assign bus.ack = ack_r;
    assign bus.nak = nak_r;
    assign bus.rdata = rdata_r;
    assign bus.host_alert_line = alert_r;
    assign input_gain_uohm = in_gain_r;
    assign max_temperature_c = temp_r;
    assign nvm_store_pulse = store_r;
endmodule // current_sense_calibration_regs
`default_nettype wire

/* File: pmbus_host_ctrl.sv */
// host end: AHB-Lite register front that issues link transactions
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"
module pmbus_host_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    pmbus_word_if.host link
);
    csc_pkg::host_state_t state_r;
    logic dp_wr_r;
    logic [7:0] dp_addr_r;
    logic [31:0] hrdata_r;
    logic [7:0] cmd_r;
    logic [1:0] kind_r;
    logic wr_r;
    logic req_r;
    csc_pkg::word_t sw_wdata_r;
    csc_pkg::word_t out_wdata_r;
    csc_pkg::word_t rdata_r;
    logic done_r;
    logic nak_r;
    logic refused_r;
    logic [7:0] page_shadow_r;
    logic [12:0] trim_shadow_r;
    logic hreadyout_r;
    logic hresp_r;

    logic ap_take;
    logic ap_rd;
    logic w_cmd;
    logic w_wdata;
    logic w_stat;
    logic [7:0] n_cmd;
    logic [1:0] n_kind;
    logic n_wr;
    logic needs_word;
    logic refuse;
    logic launch;
    logic fin;
    logic [31:0] status_w;
    logic [31:0] rd_mux;

    // zero-wait slave; only whole-word singles are expected
    assign ap_take = hsel & htrans[1] & hready;
    assign ap_rd = ap_take & ~hwrite;
    assign w_cmd = dp_wr_r & (dp_addr_r == `HREG_CMD);
    assign w_wdata = dp_wr_r & (dp_addr_r == `HREG_WDATA);
    assign w_stat = dp_wr_r & (dp_addr_r == `HREG_STATUS);
    assign n_cmd = hwdata[7:0];
    assign n_kind = hwdata[9:8];
    assign n_wr = hwdata[10];
    assign needs_word = (n_cmd == `CMD_ISC) | (n_cmd == `CMD_GAIN);
    // refusing here keeps non-word ISC and gain kinds and off-page ISC accesses off the link
    assign refuse = w_cmd & ((state_r != csc_pkg::HS_IDLE) |
        (needs_word & (n_kind != `KIND_WORD)) |
        ((n_cmd == `CMD_ISC) & (page_shadow_r != 8'h00)));
    assign launch = w_cmd & ~refuse;
    assign fin = (state_r == csc_pkg::HS_WAIT) & link.ack;
    assign status_w = {27'h0, link.host_alert_line, refused_r, nak_r, done_r,
        state_r == csc_pkg::HS_WAIT};
    assign rd_mux = (haddr[7:0] == `HREG_CMD) ? {21'h0, wr_r, kind_r, cmd_r} :
        (haddr[7:0] == `HREG_WDATA) ? {16'h0, sw_wdata_r} :
        (haddr[7:0] == `HREG_RDATA) ? {16'h0, rdata_r} :
        (haddr[7:0] == `HREG_STATUS) ? status_w : 32'h0;

    // bus phases
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dp_wr_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            dp_wr_r <= ap_take & hwrite & (hsize == 3'h2);
            if (ap_take) dp_addr_r <= haddr[7:0];
            if (ap_rd) hrdata_r <= rd_mux;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    // transaction sequencer: hold req until the device acks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= csc_pkg::HS_IDLE;
            req_r <= 1'b0;
            cmd_r <= 8'h00;
            kind_r <= `KIND_SEND;
            wr_r <= 1'b0;
            out_wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
        end else begin
            case (state_r)
                csc_pkg::HS_IDLE: begin
                    if (launch) begin
                        state_r <= csc_pkg::HS_WAIT;
                        req_r <= 1'b1;
                        cmd_r <= n_cmd;
                        kind_r <= n_kind;
                        wr_r <= n_wr;
                        // trim bits go back as last read from the device
                        out_wdata_r <= (n_cmd == `CMD_ISC) ?
                            {sw_wdata_r[15:13], trim_shadow_r} : sw_wdata_r;
                    end
                end
                csc_pkg::HS_WAIT: begin
                    if (link.ack) begin
                        state_r <= csc_pkg::HS_IDLE;
                        req_r <= 1'b0;
                        if (~wr_r) rdata_r <= link.rdata;
                    end
                end
                default: begin
                    state_r <= csc_pkg::HS_IDLE;
                    req_r <= 1'b0;
                end
            endcase
        end
    end

    // software data, sticky flags (set wins over clear) and shadows
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sw_wdata_r <= 16'h0000;
            done_r <= 1'b0;
            nak_r <= 1'b0;
            refused_r <= 1'b0;
            page_shadow_r <= 8'h00;
            trim_shadow_r <= 13'h0000;
        end else begin
            if (w_wdata) sw_wdata_r <= hwdata[15:0];
            done_r <= fin | (done_r & ~(w_stat & hwdata[`HST_DONE]));
            nak_r <= (fin & link.nak) | (nak_r & ~(w_stat & hwdata[`HST_NAK]));
            refused_r <= refuse | (refused_r & ~(w_stat & hwdata[`HST_REFUSED]));
            if (fin & wr_r & (cmd_r == `CMD_PAGE) & ~link.nak) begin
                page_shadow_r <= out_wdata_r[7:0];
            end
            if (fin & ~wr_r & (cmd_r == `CMD_ISC)) trim_shadow_r <= link.rdata[12:0];
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = hresp_r;
    assign link.req = req_r;
    assign link.cmd = cmd_r;
    assign link.kind = kind_r;
    assign link.wr = wr_r;
    assign link.wdata = out_wdata_r;
endmodule // pmbus_host_ctrl
`default_nettype wire

/* File: current_sense_calibration_regs_asserts.sv */
// concurrent checks on the word link between host controller and calibration regs
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"
module current_sense_calibration_regs_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [7:0] cmd,
    input wire logic [1:0] kind,
    input wire logic wr,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic nak,
    input wire logic [15:0] rdata,
    input wire logic host_alert_line
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // answered gain reads and out-of-range gain writes still waiting
    wire gain_rd = ack && !nak && !wr && cmd == `CMD_GAIN;
    wire bad_man = wdata[10:0] > `GAIN_MAN_MAX || wdata[10:0] < `GAIN_MAN_MIN;
    wire bad_gain = req && !ack && wr && cmd == `CMD_GAIN && kind == `KIND_WORD && bad_man;
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
    property p_answer; req && !ack |-> ##[1:2] ack; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_ack_cause; ack |-> $past(req); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_gain_exp; gain_rd |-> rdata[15:11] == `GAIN_EXP; endproperty
    a_gain_exp: assert property (p_gain_exp) else $error("gain exponent");
    property p_gain_man; gain_rd |-> rdata[10:0] inside {[`GAIN_MAN_MIN:`GAIN_MAN_MAX]}; endproperty
    a_gain_man: assert property (p_gain_man) else $error("gain mantissa");
    property p_bad_gain; bad_gain |-> ##[1:2] (ack && nak); endproperty
    a_bad_gain: assert property (p_bad_gain) else $error("bad gain taken");
    property p_alert; ack && nak |-> ##[0:1] host_alert_line; endproperty
    a_alert: assert property (p_alert) else $error("no alert");
    property p_isc_zero; ack && !nak && !wr && cmd == `CMD_ISC |-> !rdata[13]; endproperty
    a_isc_zero: assert property (p_isc_zero) else $error("isc bit 13 set");
endmodule // current_sense_calibration_regs_asserts
`default_nettype wire

/* File: tb_current_sense_calibration_regs.sv */
// self-checking bench: host controller and calibration regs joined by the link
`timescale 1ns/10ps
`default_nettype none
`include "csc_params.svh"
module tb_current_sense_calibration_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] tsel = 3'h0;
    logic [191:0] samp;
    logic [31:0] rd;
    logic [15:0] st;
    wire hreadyout;
    wire hresp;
    wire [31:0] hrdata;
    wire [12:0] gain_uohm;
    wire [7:0] temp_c;
    wire store_p;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int stores = 0;
    logic [31:0] ain [8] = '{32'h96, 32'hfa, 32'h12c, 32'h1f4, 32'h4b0, 32'h7d0, 32'h960, 32'hfa0};
    logic [7:0] pg [4] = '{8'h0, 8'h1, 8'h0, 8'h1};
    logic [7:0] ph [4] = '{8'h0, 8'h1, 8'h80, 8'h80};
    logic [15:0] iout [4] = '{16'he010, 16'he080, 16'he150, 16'he390};
    pmbus_word_if lnk ();
    pmbus_host_ctrl i_pmbus_host_ctrl (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(lnk.host));
    current_sense_calibration_regs i_current_sense_calibration_regs (.clk(clk), .rst(rst),
        .bus(lnk.device), .phase_sample_flat(samp), .max_temperature_sel(tsel),
        .input_gain_uohm(gain_uohm), .max_temperature_c(temp_c), .nvm_store_pulse(store_p));
    current_sense_calibration_regs_asserts i_current_sense_calibration_regs_asserts (
        .clk(clk), .rst(rst), .req(lnk.req), .cmd(lnk.cmd), .kind(lnk.kind), .wr(lnk.wr),
        .wdata(lnk.wdata), .ack(lnk.ack), .nak(lnk.nak), .rdata(lnk.rdata),
        .host_alert_line(lnk.host_alert_line));
    initial begin
        forever #4 clk = ~clk;
    end
    // hang guard well above the fewer than one thousand cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (store_p === 1'b1) stores++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end
    task automatic summarize();
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one single ahb transfer; read data lands in rd
    task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // one link transaction: status kept in st, read answer in rd
    task automatic op(input logic [7:0] c, input logic [1:0] k, input logic w, input logic [15:0] d);
        ahb(8'h04, 1'b1, {16'h0, d});
        ahb(8'h00, 1'b1, {21'h0, w, k, c});
        do ahb(8'h0c, 1'b0, 32'h0); while (rd[1] !== 1'b1 && rd[3] !== 1'b1);
        st = rd[15:0];
        ahb(8'h0c, 1'b1, 32'h1f);
        ahb(8'h08, 1'b0, 32'h0);
    endtask
    task automatic sel(input logic [7:0] c, input logic [7:0] v);
        op(c, `KIND_BYTE, 1'b1, {8'h0, v});
    endtask
    task automatic gw(input logic [15:0] d);
        op(`CMD_GAIN, `KIND_WORD, 1'b1, d);
    endtask
    task automatic gchk(input logic [15:0] e);
        op(`CMD_GAIN, `KIND_WORD, 1'b0, 16'h0);
        chk("gain", rd, {16'h0, e});
    endtask
    initial begin
        for (int i = 0; i < 12; i++) samp[i*16 +: 16] <= 16'(16 * (i + 1));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        chk("input gain", {19'h0, gain_uohm}, 32'h1f4);
        for (int i = 0; i < 8; i++) begin
            tsel <= 3'(i);
            repeat (3) @(posedge clk);
            chk("max temp", {24'h0, temp_c}, 32'(90 + 5 * i));
        end
        // per-phase and total readback at nominal gain, each read twice
        for (int i = 0; i < 4; i++) begin
            sel(`CMD_PAGE, pg[i]);
            sel(`CMD_PHASE, ph[i]);
            repeat (2) begin
                op(`CMD_IOUT, `KIND_WORD, 1'b0, 16'h0);
                chk("iout", rd, {16'h0, iout[i]});
            end
        end
        for (int b = 0; b < 2; b++) begin
            sel(`CMD_PAGE, 8'h1);
            op(`CMD_IMAX, `KIND_WORD, 1'b1, 16'(b << 13));
            sel(`CMD_PAGE, 8'h0);
            for (int s = 0; s < 4; s++) begin
                op(`CMD_ISC, `KIND_WORD, 1'b1, {2'(s), 14'h2000});
                chk("input gain", {19'h0, gain_uohm}, ain[b*4+s]);
                op(`CMD_ISC, `KIND_WORD, 1'b0, 16'h0);
                chk("isc", rd, {16'h0, 2'(s), 14'h0});
            end
        end
        op(`CMD_IMAX, `KIND_WORD, 1'b1, 16'h3200);
        op(`CMD_IMAX, `KIND_WORD, 1'b0, 16'h0);
        chk("max scaling", rd, 32'h3200);
        op(`CMD_ISC, `KIND_BYTE, 1'b0, 16'h0);
        chk("isc byte", 32'(st[3]), 32'h1);
        op(`CMD_GAIN, `KIND_BYTE, 1'b0, 16'h0);
        chk("gain byte", 32'(st[3]), 32'h1);
        sel(`CMD_PAGE, 8'h1);
        op(`CMD_ISC, `KIND_WORD, 1'b1, 16'h0);
        chk("isc page", 32'(st[3]), 32'h1);
        sel(`CMD_PAGE, 8'h0);
        sel(`CMD_PHASE, 8'h0);
        gw(16'hd13d);
        gchk(16'hd13d);
        gw(16'hd151);
        chk("gain nak", {30'h0, st[4], st[2]}, 32'h3);
        gchk(16'hd13d);
        gw(16'h013d);
        chk("exp nak", 32'(st[2]), 32'h1);
        op(`CMD_CLEAR, `KIND_SEND, 1'b1, 16'h0);
        ahb(8'h0c, 1'b0, 32'h0);
        chk("alert", 32'(rd[4]), 32'h0);
        sel(`CMD_PAGE, 8'hff);
        gw(16'hd145);
        sel(`CMD_PAGE, 8'h1);
        gchk(16'hd145);
        sel(`CMD_PAGE, 8'h0);
        gchk(16'hd145);
        sel(`CMD_PHASE, 8'hff);
        gw(16'hd132);
        sel(`CMD_PHASE, 8'h5);
        gchk(16'hd132);
        sel(`CMD_PHASE, 8'h80);
        gw(16'hd150);
        gchk(16'hd150);
        sel(`CMD_PHASE, 8'h0);
        gchk(16'hd132);
        op(`CMD_STORE, `KIND_SEND, 1'b1, 16'h0);
        chk("store", 32'(stores), 32'h1);
        chk("hresp", 32'(hresp), 32'h0);
        summarize();
    end
endmodule // tb_current_sense_calibration_regs
`default_nettype wire
